// >>> fsc_core.sv
// Overview of operation
// - scan built from start frequency, step size and increment count.
// - auto mode times each step by clock periods or output cycles.
// - auto mode: one trigger pulse starts and completes whole scan.
// - external mode: first trigger edge starts, each later edge steps once until the count runs out; the next edge ends the scan.
// - phase accumulator keeps running; only its increment changes.
// - final frequency held until reset.
// - scan lasts increment count plus one intervals.
// - each write is one 16-bit word on the serial clock.
// - one bit per falling serial clock edge, sixteen per word.
// - bits accepted only while frame sync is low.
// - long frame: each group of sixteen bits is its own word.
// - serial clock may run or idle high or low.
// - control write resets scan and sets output midscale like abort.
// - output stays midscale until a trigger rising edge.
// - top four bits address the register; zero means control.
// - abort sampled by clock; rising edge resets scan to midscale.
// - trigger sampled by clock; rising edge starts the scan.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module fsc_core
  import fsc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic serial_data_in_i,
  input wire logic frame_sync_n_i,
  input wire logic scan_trigger_i,
  input wire logic abort_i,
  output logic [9:0] dac_code_o,
  output logic dac_enable_o,
  output logic msb_out_o,
  output logic msb_out_oe_o,
  output logic [23:0] current_freq_o,
  output logic scan_active_o,
  output logic scan_done_o
);
  fsc_core_s r_reg;
  fsc_core_s r_next;
  logic word_valid;
  fsc_word_s word;
  logic trig_rise;
  logic abort_rise;
  logic ctrl_wr;
  logic kill;
  logic [24:0] phase_sum;
  logic ext_mode;
  logic [12:0] intv_len;
  logic intv_tick;
  logic intv_end;
  logic step_now;

  // ==========================================================
  // serial port, delivering words already in the clock domain
  fsc_serial_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i),
    .serial_data_in_i(serial_data_in_i),
    .frame_sync_n_i(frame_sync_n_i),
    .word_valid_o(word_valid),
    .word_o(word)
  );

  // ==========================================================
  // edge detect on filtered trigger and abort
  assign trig_rise = (r_reg.trig_sync[1] == r_reg.trig_sync[2]) & r_reg.trig_sync[2] & ~r_reg.trig_f;
  assign abort_rise = (r_reg.abort_sync[1] == r_reg.abort_sync[2]) & r_reg.abort_sync[2] & ~r_reg.abort_f;
  assign ctrl_wr = word_valid & (word.addr == `FSC_ADDR_CTRL);
  assign kill = abort_rise | ctrl_wr;

  // interval timing helpers
  assign phase_sum = {1'b0, r_reg.phase} + {1'b0, r_reg.freq};
  assign ext_mode = r_reg.cfg.ctrl[`FSC_CTRL_EXT_INC];
  assign intv_len = (r_reg.cfg.intv[12:0] == 13'h0) ? 13'h1 : r_reg.cfg.intv[12:0];
  assign intv_tick = r_reg.cfg.intv[`FSC_INTV_BASE_BIT] ? phase_sum[24] : 1'b1; // cycles or clocks
  assign intv_end = intv_tick & ((r_reg.icnt + 13'h1) >= intv_len);
  assign step_now = ext_mode ? trig_rise : intv_end;

  // next state
  always_comb begin
    r_next = r_reg;
    r_next.trig_sync = {r_reg.trig_sync[1:0], scan_trigger_i};
    r_next.abort_sync = {r_reg.abort_sync[1:0], abort_i};
    if (r_reg.trig_sync[1] == r_reg.trig_sync[2]) begin
      r_next.trig_f = r_reg.trig_sync[2];
    end
    if (r_reg.abort_sync[1] == r_reg.abort_sync[2]) begin
      r_next.abort_f = r_reg.abort_sync[2];
    end

    // register writes by address nibble
    if (word_valid) begin
      case (word.addr)
        `FSC_ADDR_CTRL: begin
          r_next.cfg.ctrl = word.data;
        end
        `FSC_ADDR_NINC: begin
          r_next.cfg.ninc = word.data;
        end
        `FSC_ADDR_DF_LO: begin
          if (r_reg.cfg.ctrl[`FSC_CTRL_B24]) begin
            r_next.cfg.df_lo_pend = word.data;
          end else begin
            r_next.cfg.dfreq[11:0] = word.data;
          end
        end
        `FSC_ADDR_DF_HI: begin
          r_next.cfg.dfreq[23:12] = word.data;
          if (r_reg.cfg.ctrl[`FSC_CTRL_B24]) begin
            r_next.cfg.dfreq[11:0] = r_reg.cfg.df_lo_pend; // both halves land together
          end
        end
        `FSC_ADDR_FS_LO: begin
          if (r_reg.cfg.ctrl[`FSC_CTRL_B24]) begin
            r_next.cfg.fs_lo_pend = word.data;
          end else begin
            r_next.cfg.start_frequency[11:0] = word.data;
          end
        end
        `FSC_ADDR_FS_HI: begin
          r_next.cfg.start_frequency[23:12] = word.data;
          if (r_reg.cfg.ctrl[`FSC_CTRL_B24]) begin
            r_next.cfg.start_frequency[11:0] = r_reg.cfg.fs_lo_pend;
          end
        end
        default: begin
          if (word.addr[3:2] == `FSC_ADDR_INTV_TOP) begin
            r_next.cfg.intv = {word.addr[1:0], word.data};
          end
        end
      endcase
    end

    // phase runs without reload across steps
    if (r_reg.state != fsc_st_idle) begin
      r_next.phase = phase_sum[23:0];
    end

    // scan sequencing
    case (r_reg.state)
      fsc_st_idle: begin
        if (trig_rise) begin
          r_next.state = fsc_st_run;
          r_next.freq = r_reg.cfg.start_frequency;
          r_next.steps = r_reg.cfg.ninc;
          r_next.icnt = 13'h0;
          r_next.phase = 24'h0;
        end
      end
      fsc_st_run: begin
        if (intv_tick && !ext_mode) begin
          r_next.icnt = intv_end ? 13'h0 : r_reg.icnt + 13'h1;
        end
        if (step_now) begin
          if (r_reg.steps == 12'h0) begin
            r_next.state = fsc_st_hold; // start interval plus n steps elapsed
            r_next.done = 1'b1;
          end else begin
            r_next.freq = r_reg.freq + r_reg.cfg.dfreq;
            r_next.steps = r_reg.steps - 12'h1;
          end
        end
      end
      fsc_st_hold: begin
        r_next.state = fsc_st_hold; // last frequency kept
      end
      default: begin
        r_next.state = fsc_st_idle;
      end
    endcase

    // output sample: midscale while idle, triangle of phase otherwise
    if (r_next.state == fsc_st_idle) begin
      r_next.dac = `FSC_DAC_MID;
    end else if (r_next.phase[`FSC_PHASE_MSB]) begin
      r_next.dac = ~r_next.phase[22:13];
    end else begin
      r_next.dac = r_next.phase[22:13];
    end

    // abort or control write returns to idle at midscale
    if (kill) begin
      r_next.state = fsc_st_idle;
      r_next.dac = `FSC_DAC_MID;
      r_next.phase = 24'h0;
      r_next.icnt = 13'h0;
      r_next.done = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.state <= fsc_st_idle;
      r_reg.dac <= `FSC_DAC_MID;
      r_reg.cfg.ctrl <= `FSC_RST_CTRL;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  assign dac_code_o = r_reg.dac;
  assign dac_enable_o = r_reg.cfg.ctrl[`FSC_CTRL_DAC_EN];
  assign msb_out_o = ~r_reg.phase[`FSC_PHASE_MSB]; // inverted phase msb
  assign msb_out_oe_o = r_reg.cfg.ctrl[`FSC_CTRL_MSB_EN];
  assign current_freq_o = r_reg.freq;
  assign scan_active_o = (r_reg.state == fsc_st_run);
  assign scan_done_o = r_reg.done;

  // ==========================================================
  // checks
  sequence s_start_req;
    (r_reg.state == fsc_st_idle) && trig_rise && !kill;
  endsequence
  sequence s_started;
    (r_reg.state == fsc_st_run) && (r_reg.freq == $past(r_reg.cfg.start_frequency)) && (r_reg.phase == 24'h0);
  endsequence

  property p_start;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_start_req |=> s_started;
  endproperty
  a_start: assert property (p_start) else $error("trigger did not start scan");

  property p_ctrl_reset;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl_wr |=> (r_reg.state == fsc_st_idle) && (dac_code_o == `FSC_DAC_MID);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control write did not reset scan");

  property p_abort;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    abort_rise |=> (r_reg.state == fsc_st_idle) && (dac_code_o == `FSC_DAC_MID) && !scan_done_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not reset scan");

  property p_idle_mid;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (r_reg.state == fsc_st_idle) |-> (dac_code_o == `FSC_DAC_MID);
  endproperty
  a_idle_mid: assert property (p_idle_mid) else $error("output not midscale while idle");

  property p_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((r_reg.state == fsc_st_hold) && !kill) |=> (r_reg.state == fsc_st_hold) && $stable(current_freq_o);
  endproperty
  a_hold: assert property (p_hold) else $error("final frequency not held");

  property p_phase_cont;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((r_reg.state == fsc_st_run) && !kill) |=> (r_reg.phase == 24'($past(r_reg.phase) + $past(r_reg.freq)));
  endproperty
  a_phase_cont: assert property (p_phase_cont) else $error("phase jumped");

  property p_ext_step;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((r_reg.state == fsc_st_run) && ext_mode && trig_rise && !kill && (r_reg.steps != 12'h0))
      |=> (current_freq_o == 24'($past(r_reg.freq) + $past(r_reg.cfg.dfreq)));
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("external edge did not step");

  property p_ext_wait;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((r_reg.state == fsc_st_run) && ext_mode && !trig_rise && !kill) |=> $stable(current_freq_o);
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("step without external edge");

  property p_auto_clock_step;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((r_reg.state == fsc_st_run) && !ext_mode && !r_reg.cfg.intv[`FSC_INTV_BASE_BIT] && !kill
      && (r_reg.icnt + 13'h1 < intv_len)) |=> $stable(current_freq_o) && (r_reg.icnt == $past(r_reg.icnt) + 13'h1);
  endproperty
  a_auto_clock_step: assert property (p_auto_clock_step) else $error("auto step before interval end");
endmodule : fsc_core
`default_nettype wire

// >>> fsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
  output logic sclk_o,
  output logic serial_data_in_o,
  output logic frame_sync_n_o
);
  // ==========================================================
  // idle pins: frame released, clock parked high
  initial begin
    sclk_o = 1'b1;
    serial_data_in_o = 1'b0;
    frame_sync_n_o = 1'b1;
  end

  // ==========================================================
  // shift nbits of w, msb first; 16 or 32 gives whole words, fewer cuts the frame short
  task automatic send(input logic [31:0] w, input int nbits, input logic idle_hi);
    int i;
    frame_sync_n_o = 1'b0;
    #16;
    for (i = nbits - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      serial_data_in_o = w[i];
      #16;
      sclk_o = 1'b0; // bit taken on this fall
      #16;
    end
    #16;
    frame_sync_n_o = 1'b1; // only after the last fall
    serial_data_in_o = ~serial_data_in_o; // released line shows no stale bit
    sclk_o = idle_hi; // park either way between writes
    #40;
  endtask : send
endmodule : fsc_host_model
`default_nettype wire

// >>> fsc_map.svh
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
// ==========================================================
// serial word layout
`define FSC_BIT_CNT_LAST 4'hf
`define FSC_ADDR_CTRL 4'h0
`define FSC_ADDR_NINC 4'h1
`define FSC_ADDR_DF_LO 4'h2
`define FSC_ADDR_DF_HI 4'h3
`define FSC_ADDR_INTV_TOP 2'h1
`define FSC_ADDR_FS_LO 4'hc
`define FSC_ADDR_FS_HI 4'hd
// ==========================================================
// control word fields
`define FSC_CTRL_B24 11
`define FSC_CTRL_DAC_EN 10
`define FSC_CTRL_MSB_EN 8
`define FSC_CTRL_EXT_INC 5
`define FSC_RST_CTRL 12'h0c0
// ==========================================================
// step interval word fields
`define FSC_INTV_BASE_BIT 13
// ==========================================================
// output levels
`define FSC_DAC_MID 10'h200
`define FSC_PHASE_MSB 23
`endif

// >>> fsc_pkg.sv
`default_nettype none
package fsc_pkg;
  // ==========================================================
  // scan states, one-hot
  typedef enum logic [2:0] {
    fsc_st_idle = 3'b001,
    fsc_st_run = 3'b010,
    fsc_st_hold = 3'b100
  } fsc_state_e;

  // ==========================================================
  // one serial word: address nibble and payload
  typedef struct packed {
    logic [3:0] addr;
    logic [11:0] data;
  } fsc_word_s;

  // serial receiver state
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] data_sync;
    logic [2:0] fs_sync;
    logic sclk_f;
    logic fs_f;
    logic [3:0] cnt;
    logic [15:0] shift;
    logic valid;
    fsc_word_s word;
  } fsc_rx_s;

  // scan configuration
  typedef struct packed {
    logic [11:0] ctrl;
    logic [11:0] ninc;
    logic [23:0] dfreq;
    logic [13:0] intv;
    logic [23:0] start_frequency;
    logic [11:0] df_lo_pend;
    logic [11:0] fs_lo_pend;
  } fsc_cfg_s;

  // scan core state
  typedef struct packed {
    fsc_cfg_s cfg;
    fsc_state_e state;
    logic [2:0] trig_sync;
    logic trig_f;
    logic [2:0] abort_sync;
    logic abort_f;
    logic [23:0] freq;
    logic [23:0] phase;
    logic [11:0] steps;
    logic [12:0] icnt;
    logic [9:0] dac;
    logic done;
  } fsc_core_s;
endpackage : fsc_pkg
`default_nettype wire

// >>> fsc_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module fsc_serial_rx
  import fsc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic serial_data_in_i,
  input wire logic frame_sync_n_i,
  output logic word_valid_o,
  output fsc_word_s word_o
);
  fsc_rx_s r_reg;
  fsc_rx_s r_next;
  logic sclk_fall;

  // ==========================================================
  // falling serial clock, once stages two and three agree low
  assign sclk_fall = r_reg.sclk_f & (r_reg.sclk_sync[1] == r_reg.sclk_sync[2]) & ~r_reg.sclk_sync[2];

  // shift, count and frame logic
  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    r_next.sclk_sync = {r_reg.sclk_sync[1:0], sclk_i};
    r_next.data_sync = {r_reg.data_sync[1:0], serial_data_in_i};
    r_next.fs_sync = {r_reg.fs_sync[1:0], frame_sync_n_i};
    if (r_reg.sclk_sync[1] == r_reg.sclk_sync[2]) begin
      r_next.sclk_f = r_reg.sclk_sync[2]; // clock idles high or low alike
    end
    if (r_reg.fs_sync[1] == r_reg.fs_sync[2]) begin
      r_next.fs_f = r_reg.fs_sync[2];
    end
    if (r_reg.fs_f) begin
      r_next.cnt = 4'h0; // frame high: drop partial word
    end else if (sclk_fall) begin
      r_next.shift = {r_reg.shift[14:0], r_reg.data_sync[2]}; // one bit per falling edge
      r_next.cnt = r_reg.cnt + 4'h1; // wraps: next group of 16 is a new word
      if (r_reg.cnt == `FSC_BIT_CNT_LAST) begin
        r_next.valid = 1'b1; // only the sixteenth edge delivers
        r_next.word = {r_reg.shift[14:0], r_reg.data_sync[2]};
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.sclk_sync <= 3'b111; // idle levels, no false low after release
      r_reg.fs_sync <= 3'b111;
      r_reg.sclk_f <= 1'b1;
      r_reg.fs_f <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign word_valid_o = r_reg.valid;
  assign word_o = r_reg.word;

  // ==========================================================
  // checks
  property p_frame_gates;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    r_reg.fs_f |=> (r_reg.cnt == 4'h0) && !word_valid_o;
  endproperty
  a_frame_gates: assert property (p_frame_gates) else $error("bit counted while frame high");

  property p_sixteen;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (!r_reg.fs_f && sclk_fall && r_reg.cnt == `FSC_BIT_CNT_LAST) |=> word_valid_o;
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("word missing after 16 edges");

  property p_no_partial;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    word_valid_o |-> ($past(r_reg.cnt) == `FSC_BIT_CNT_LAST) && !$past(r_reg.fs_f) && $past(sclk_fall);
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("word delivered early");
endmodule : fsc_serial_rx
`default_nettype wire

// >>> test_frequency_scan_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_frequency_scan_controller;
  import fsc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scan_trigger_i = 1'b0;
  logic abort_i = 1'b0;
  wire logic sclk, ser_data, fs_n;
  logic [9:0] dac_code;
  logic dac_enable, msb_out, msb_out_oe, scan_active, scan_done;
  logic [23:0] current_freq;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int act_at = 0;
  localparam logic [23:0] F0 = 24'h123456;
  localparam logic [23:0] D0 = 24'h000789;
  localparam int L0 = 20;

  // ==========================================================
  // clock, cycle count
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  // cycle at which scan_active last rose, frozen while it stays high
  always @(posedge clk_sys_i) if (scan_active !== 1'b1) act_at <= cyc + 1;

  fsc_host_model i_host (.sclk_o(sclk), .serial_data_in_o(ser_data), .frame_sync_n_o(fs_n));

  fsc_core i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .serial_data_in_i(ser_data),
    .frame_sync_n_i(fs_n), .scan_trigger_i(scan_trigger_i), .abort_i(abort_i),
    .dac_code_o(dac_code), .dac_enable_o(dac_enable), .msb_out_o(msb_out), .msb_out_oe_o(msb_out_oe),
    .current_freq_o(current_freq), .scan_active_o(scan_active), .scan_done_o(scan_done)
  );

  // ==========================================================
  // compare, waits and pin pulses
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // sel 0: active, 1: done, 2: frequency leaves v
  task automatic wait_until(input int sel, input logic [23:0] v, output int at);
    int n;
    n = 0;
    while (n < 3000 && !((sel == 0 && scan_active === 1'b1) || (sel == 1 && scan_done === 1'b1) ||
        (sel == 2 && current_freq !== v))) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 3000) chk(24'h0, 24'h1);
    at = (sel == 0) ? act_at : cyc; // sel 0 gives the start cycle itself
  endtask : wait_until

  task automatic pulse(input logic is_abort);
    @(negedge clk_sys_i);
    if (is_abort) abort_i = 1'b1;
    else scan_trigger_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    abort_i = 1'b0;
    scan_trigger_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
  endtask : pulse

  task automatic wr(input logic [31:0] w, input int nbits, input logic idle_hi);
    @(negedge clk_sys_i);
    i_host.send(w, nbits, idle_hi);
    repeat (10) @(negedge clk_sys_i);
  endtask : wr

  // ==========================================================
  // scenarios
  task automatic test_reset();
    chk({14'h0, dac_code}, 24'h200);
    chk({19'h0, scan_active, scan_done, msb_out_oe, dac_enable, msb_out}, 24'h1);
    chk(current_freq, 24'h0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_auto_clock();
    int a0, t;
    wr({16'h05c0, 16'h1002}, 32, 1'b1); // control first, long frame
    wr({16'h2789, 16'h3000}, 32, 1'b0); // idle low between writes
    wr({16'hc456, 16'hd123}, 32, 1'b1);
    wr({16'h0, 16'h4000 | 16'(L0)}, 16, 1'b1); // clock base interval
    chk({22'h0, dac_enable, msb_out_oe}, 24'h3);
    chk({14'h0, dac_code}, 24'h200); // still midscale before trigger
    pulse(1'b0); // one pulse runs the whole scan
    wait_until(0, 24'h0, a0);
    wait_until(2, F0, t);
    chk(24'(t - a0), 24'(L0));
    chk(current_freq, F0 + D0);
    wait_until(2, F0 + D0, t);
    chk(24'(t - a0), 24'(2 * L0));
    chk(current_freq, F0 + D0 + D0);
    wait_until(1, 24'h0, t);
    chk(24'(t - a0), 24'(3 * L0)); // (N+1) intervals
    repeat (100) @(negedge clk_sys_i);
    pulse(1'b0); // trigger ignored while holding
    chk(current_freq, F0 + D0 + D0);
    chk({23'h0, scan_done}, 24'h1);
    $display("test_auto_clock done");
  endtask : test_auto_clock

  task automatic test_refused();
    wr({23'h0, 9'h001}, 9, 1'b0); // cut-short control word
    chk({23'h0, scan_done}, 24'h1);
    wr({16'h0, 16'h8abc}, 16, 1'b1); // reserved address
    chk({23'h0, scan_done}, 24'h1);
    wr({16'h0, 16'h0de0}, 16, 1'b1); // b24 on, external mode
    chk({22'h0, scan_done, scan_active}, 24'h0);
    chk({14'h0, dac_code}, 24'h200);
    $display("test_refused done");
  endtask : test_refused

  task automatic test_ext();
    int k;
    wr({16'h0, 16'hc000}, 16, 1'b1); // low half pending until high half
    wr({23'h0, 9'h19f}, 9, 1'b1); // partial low half discarded
    pulse(1'b0); // first edge starts
    chk({23'h0, scan_active}, 24'h1);
    chk(current_freq, F0);
    for (k = 1; k <= 2; k++) begin
      repeat (100) @(negedge clk_sys_i);
      chk(current_freq, F0 + 24'(k - 1) * D0); // no self timing
      pulse(1'b0);
      chk(current_freq, F0 + 24'(k) * D0);
    end
    pulse(1'b0);
    chk({22'h0, scan_done, scan_active}, 24'h2);
    chk(current_freq, F0 + D0 + D0);
    pulse(1'b1);
    chk({22'h0, scan_done, scan_active}, 24'h0);
    chk({14'h0, dac_code}, 24'h200);
    $display("test_ext done");
  endtask : test_ext

  task automatic test_auto_cycles();
    int a0, t;
    wr({16'h05c0, 16'hc000}, 32, 1'b1);
    wr({16'hd400, 16'h2000}, 32, 1'b0);
    wr({16'h3000, 16'h1001}, 32, 1'b1);
    wr({16'h0, 16'h6003}, 16, 1'b1); // 3 output cycles per step
    pulse(1'b0);
    wait_until(0, 24'h0, a0);
    chk(current_freq, 24'h400000);
    wait_until(1, 24'h0, t);
    t = t - a0;
    chk({23'h0, t >= 22 && t <= 26}, 24'h1); // 2 x 3 cycles of 4 clocks
    chk({23'h0, dac_code !== 10'h200}, 24'h1); // output keeps running
    $display("test_auto_cycles done");
  endtask : test_auto_cycles

  // ==========================================================
  // verdict, the single place the run ends
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    test_reset();
    test_auto_clock();
    test_refused();
    test_ext();
    test_auto_cycles();
    tally_and_finish();
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_frequency_scan_controller
`default_nettype wire
